// [fcfr_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module fcfr_regs
  import fcfr_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // register access from host interface
  input  wire fcfr_pkg::fcfr_req_s req,
  output logic [7:0]             rdata,
  // buffer data side
  input  wire logic [7:0]        buf_rdata,
  output logic                   buf_push,
  output logic                   buf_pop,
  output logic                   buffer_clear,
  // controls toward the device
  output fcfr_pkg::fcfr_cmd_s    cmd,
  output fcfr_pkg::fcfr_owner_s  owner,
  output logic                   buffer_size_select,
  output logic [9:0]             fill_count,
  output logic                   high_water_flag,
  output logic                   low_water_flag
);
  import fcfr_pkg::*;

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  logic       standby_r, standby_nxt;
  logic       radio_off_r, radio_off_nxt;
  logic [4:0] command_r, command_nxt;
  logic       cmd_wr_r, cmd_wr_nxt;
  logic       unlock_r, unlock_nxt;
  logic       own_ctrl_r, own_ctrl_nxt;
  logic       own_sec_r, own_sec_nxt;
  logic [1:0] if_sel_r, if_sel_nxt;
  logic       size_r, size_nxt;
  logic [8:0] thr_r, thr_nxt;
  logic [9:0] count_r, count_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       wr_cmd, wr_own, wr_bc, wr_thr, wr_data, rd_data;
  logic       flush;
  logic       hi_f, lo_f;
  logic [9:0] cap;

  // -------------------------------------------------------------
  // decode
  // -------------------------------------------------------------
  always_comb begin
    wr_cmd  = req.wr && (req.addr == FCFR_ADDR_CMD);
    wr_own  = req.wr && (req.addr == FCFR_ADDR_OWNER);
    wr_bc   = req.wr && (req.addr == FCFR_ADDR_BUFCTL);
    wr_thr  = req.wr && (req.addr == FCFR_ADDR_THRESH);
    wr_data = req.wr && (req.addr == FCFR_ADDR_DATA);
    rd_data = req.rd && (req.addr == FCFR_ADDR_DATA);
    flush   = wr_bc && req.wdata[FCFR_BC_CLEAR];
    cap     = size_r ? FCFR_SIZE_SMALL : FCFR_SIZE_LARGE;
  end

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    standby_nxt   = standby_r;
    radio_off_nxt = radio_off_r;
    command_nxt   = command_r;
    cmd_wr_nxt    = 1'b0;
    unlock_nxt    = unlock_r;
    own_ctrl_nxt  = own_ctrl_r;
    own_sec_nxt   = own_sec_r;
    if_sel_nxt    = if_sel_r;
    size_nxt      = size_r;
    thr_nxt       = thr_r;
    count_nxt     = count_r;
    if (wr_cmd) begin
      standby_nxt   = req.wdata[FCFR_CMD_STANDBY];
      radio_off_nxt = req.wdata[FCFR_CMD_RADIO_OFF];
      command_nxt   = req.wdata[4:0];
      cmd_wr_nxt    = 1'b1;
    end
    if (wr_own) begin
      if (unlock_r) begin
        // unlock is consumed by this write, whatever its bit 7 carries
        unlock_nxt = 1'b0;
        if_sel_nxt = req.wdata[FCFR_OWN_IF_HI:FCFR_OWN_IF_LO];
        if (req.wdata[FCFR_OWN_CTRL] && req.wdata[FCFR_OWN_SECURE]) begin
          own_ctrl_nxt = own_ctrl_r;
          own_sec_nxt  = own_sec_r;
        end else begin
          own_ctrl_nxt = req.wdata[FCFR_OWN_CTRL];
          own_sec_nxt  = req.wdata[FCFR_OWN_SECURE];
        end
      end else begin
        unlock_nxt = req.wdata[FCFR_OWN_UNLOCK];
      end
    end
    if (wr_bc) begin
      size_nxt    = req.wdata[FCFR_BC_SIZE];
      thr_nxt[8]  = req.wdata[FCFR_BC_THR8];
    end
    if (wr_thr) begin
      thr_nxt[7:0] = req.wdata;
    end
    // flush wins over a simultaneous data access
    if (flush) begin
      count_nxt = 10'd0;
    end else if (wr_data && (count_r < cap)) begin
      count_nxt = count_r + 10'd1;
    end else if (rd_data && (count_r != 10'd0)) begin
      count_nxt = count_r - 10'd1;
    end
  end

  // -------------------------------------------------------------
  // read mux
  // -------------------------------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    if (req.rd) begin
      case (req.addr)
        FCFR_ADDR_CMD:    rdata_nxt = {standby_r, radio_off_r, 1'b0, command_r};
        FCFR_ADDR_OWNER:  rdata_nxt = {unlock_r, own_ctrl_r, own_sec_r, 1'b0, if_sel_r, 2'b00};
        FCFR_ADDR_BUFCTL: rdata_nxt = {size_r, hi_f, lo_f, 1'b0, 1'b0, thr_r[8],
                                       size_r ? 2'b00 : count_r[9:8]};
        FCFR_ADDR_THRESH: rdata_nxt = thr_r[7:0];
        FCFR_ADDR_COUNT:  rdata_nxt = count_r[7:0];
        FCFR_ADDR_DATA:   rdata_nxt = buf_rdata;
        default:          rdata_nxt = FCFR_RST_BYTE;
      endcase
    end
  end

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      standby_r   <= 1'b0;
      radio_off_r <= 1'b0;
      command_r   <= FCFR_CMD_IDLE;
      cmd_wr_r    <= 1'b0;
      unlock_r    <= 1'b0;
      own_ctrl_r  <= 1'b0;
      own_sec_r   <= 1'b0;
      if_sel_r    <= 2'b00;
      size_r      <= 1'b0;
      thr_r       <= 9'd0;
      count_r     <= 10'd0;
      rdata_r     <= FCFR_RST_BYTE;
    end else begin
      standby_r   <= standby_nxt;
      radio_off_r <= radio_off_nxt;
      command_r   <= command_nxt;
      cmd_wr_r    <= cmd_wr_nxt;
      unlock_r    <= unlock_nxt;
      own_ctrl_r  <= own_ctrl_nxt;
      own_sec_r   <= own_sec_nxt;
      if_sel_r    <= if_sel_nxt;
      size_r      <= size_nxt;
      thr_r       <= thr_nxt;
      count_r     <= count_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  fcfr_level u_level (
    .small_mode (size_r),
    .fill       (count_r),
    .threshold  (thr_r),
    .high_flag  (hi_f),
    .low_flag   (lo_f)
  );

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  always_comb begin
    rdata                            = rdata_r;
    buf_push                         = wr_data && !flush;
    buf_pop                          = rd_data && !flush;
    buffer_clear                     = flush;
    cmd.standby                      = standby_r;
    cmd.radio_power_off              = radio_off_r;
    cmd.command                      = command_r;
    cmd.cmd_written                  = cmd_wr_r;
    owner.bus_owned_by_controller    = own_ctrl_r;
    owner.bus_owned_by_secure_module = own_sec_r;
    owner.secure_module_if_select    = fcfr_if_e'(if_sel_r);
    buffer_size_select               = size_r;
    fill_count                       = count_r;
    high_water_flag                  = hi_f;
    low_water_flag                   = lo_f;
  end
endmodule : fcfr_regs
`default_nettype wire

// [fcfr_pkg.sv]
// Notes on behaviour
// - writing standby bit requests power-down
// - radio power-off bit disables receiver and transmitter
// - low five bits hold running command code
// - owner register writable only after unlock, self-clearing
// - controller ownership bit needs prior unlock
// - secure module ownership bit needs prior unlock
// - both ownership bits never set together
// - two-bit field selects secure module interface
// - size bit one gives 255, zero 512
// - high flag when size minus count within threshold
// - low flag when count within threshold
// - clear bit empties buffer, reads zero
// - bit 2 is threshold bit 8, 512 mode
// - bits 1:0 report count bits 9:8 in 512 mode, read zero in 255 mode
// - data write increments, data read decrements count
// - count register shows bytes held, resets zero
// - threshold register holds low eight bits of comparison level
package fcfr_pkg;
  // -------------------------------------------------------------
  // register map
  // -------------------------------------------------------------
  localparam logic [7:0] FCFR_ADDR_CMD    = 8'h00;
  localparam logic [7:0] FCFR_ADDR_OWNER  = 8'h01;
  localparam logic [7:0] FCFR_ADDR_BUFCTL = 8'h02;
  localparam logic [7:0] FCFR_ADDR_THRESH = 8'h03;
  localparam logic [7:0] FCFR_ADDR_COUNT  = 8'h04;
  localparam logic [7:0] FCFR_ADDR_DATA   = 8'h05;

  // -------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------
  localparam int FCFR_CMD_STANDBY   = 7;
  localparam int FCFR_CMD_RADIO_OFF = 6;
  localparam int FCFR_OWN_UNLOCK    = 7;
  localparam int FCFR_OWN_CTRL      = 6;
  localparam int FCFR_OWN_SECURE    = 5;
  localparam int FCFR_OWN_IF_HI     = 3;
  localparam int FCFR_OWN_IF_LO     = 2;
  localparam int FCFR_BC_SIZE       = 7;
  localparam int FCFR_BC_HIGH       = 6;
  localparam int FCFR_BC_LOW        = 5;
  localparam int FCFR_BC_CLEAR      = 4;
  localparam int FCFR_BC_THR8       = 2;

  // -------------------------------------------------------------
  // sizes and resets
  // -------------------------------------------------------------
  localparam logic [9:0] FCFR_SIZE_SMALL = 10'd255;
  localparam logic [9:0] FCFR_SIZE_LARGE = 10'd512;
  localparam logic [7:0] FCFR_RST_BYTE   = 8'h00;
  localparam logic [4:0] FCFR_CMD_IDLE   = 5'h00;

  typedef enum logic [1:0] {
    FCFR_IF_OFF   = 2'b00,
    FCFR_IF_SPI   = 2'b01,
    FCFR_IF_TWL   = 2'b10,
    FCFR_IF_TWS   = 2'b11
  } fcfr_if_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fcfr_req_s;

  typedef struct packed {
    logic       standby;
    logic       radio_power_off;
    logic [4:0] command;
    logic       cmd_written;
  } fcfr_cmd_s;

  typedef struct packed {
    logic     bus_owned_by_controller;
    logic     bus_owned_by_secure_module;
    fcfr_if_e secure_module_if_select;
  } fcfr_owner_s;
endpackage : fcfr_pkg

// [fcfr_level.sv]
`timescale 1ns/10ps
`default_nettype none
module fcfr_level
  import fcfr_pkg::*;
(
  // mode and values
  input  wire logic       small_mode,
  input  wire logic [9:0] fill,
  input  wire logic [8:0] threshold,
  // flags
  output logic            high_flag,
  output logic            low_flag
);
  logic [9:0] size;
  logic [9:0] thr;
  always_comb begin
    size = small_mode ? FCFR_SIZE_SMALL : FCFR_SIZE_LARGE;
    thr  = {1'b0, small_mode ? 1'b0 : threshold[8], threshold[7:0]};
    high_flag = ((size - fill) <= thr);
    low_flag  = (fill <= thr);
  end
endmodule : fcfr_level
`default_nettype wire

// [fcfr_buf_model.sv]
`timescale 1ns/10ps
`default_nettype none
module fcfr_buf_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // strobes from the register block
  input  wire logic       buf_push,
  input  wire logic       buf_pop,
  input  wire logic       buffer_clear,
  input  wire logic [7:0] wdata,
  // byte at the head
  output logic      [7:0] buf_rdata
);
  logic [7:0] mem [512];
  logic [8:0] wptr_r;
  logic [8:0] rptr_r;
  // empty buffer shows a moving pattern, never a stale byte
  assign buf_rdata = (wptr_r == rptr_r) ? ~rptr_r[7:0] : mem[rptr_r];
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else if (buffer_clear) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      if (buf_push) begin
        mem[wptr_r] <= wdata;
        wptr_r      <= wptr_r + 9'h001;
      end
      if (buf_pop) begin
        rptr_r <= rptr_r + 9'h001;
      end
    end
  end
endmodule : fcfr_buf_model
`default_nettype wire

// [fcfr_regs_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module fcfr_regs_sva
  import fcfr_pkg::*;
(
  // watched ports
  input wire logic                  core_clk,
  input wire logic                  nrst,
  input wire fcfr_pkg::fcfr_req_s   req,
  input wire logic [7:0]            rdata,
  input wire logic [7:0]            buf_rdata,
  input wire logic                  buf_push,
  input wire logic                  buf_pop,
  input wire logic                  buffer_clear,
  input wire fcfr_pkg::fcfr_cmd_s   cmd,
  input wire fcfr_pkg::fcfr_owner_s owner,
  input wire logic                  buffer_size_select,
  input wire logic [9:0]            fill_count,
  input wire logic                  high_water_flag,
  input wire logic                  low_water_flag
);
  logic       unlock_r;
  logic [8:0] thr_r;
  logic [9:0] thr_e;
  logic [9:0] room;
  logic [6:0] ctl_e;
  assign thr_e = buffer_size_select ? {2'b00, thr_r[7:0]} : {1'b0, thr_r};
  assign room  = (buffer_size_select ? 10'h0FF : 10'h200) - fill_count;
  assign ctl_e = {buffer_size_select, high_water_flag, low_water_flag, 2'b00,
                  buffer_size_select ? 2'b00 : fill_count[9:8]};
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      unlock_r <= 1'b0;
      thr_r    <= '0;
    end else if (req.wr) begin
      if (req.addr == 8'h01) begin
        unlock_r <= !unlock_r && req.wdata[7];
      end
      if (req.addr == 8'h03) begin
        thr_r[7:0] <= req.wdata;
      end
      if (req.addr == 8'h02) begin
        thr_r[8] <= req.wdata[2];
      end
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  cmd_write_a: assert property (
    req.wr && req.addr == 8'h00 |=> cmd == {$past(req.wdata[7:6]), $past(req.wdata[4:0]), 1'b1})
    else $error("command write mismatch");
  owner_lock_a: assert property (
    req.wr && req.addr == 8'h01 && !unlock_r |=> $stable(owner))
    else $error("owner changed while locked");
  // a both-owners write keeps ownership but still takes the interface field
  owner_both_a: assert property (
    req.wr && req.addr == 8'h01 && unlock_r && (&req.wdata[6:5])
    |=> {owner.bus_owned_by_controller, owner.bus_owned_by_secure_module}
        == $past({owner.bus_owned_by_controller, owner.bus_owned_by_secure_module})
        && owner.secure_module_if_select == $past(req.wdata[3:2]))
    else $error("both owners accepted");
  owner_set_a: assert property (
    req.wr && req.addr == 8'h01 && unlock_r && !(&req.wdata[6:5])
    |=> owner == {$past(req.wdata[6:5]), $past(req.wdata[3:2])}) else $error("owner not set");
  owner_excl_a: assert property (
    !(owner.bus_owned_by_controller && owner.bus_owned_by_secure_module))
    else $error("both owners set");
  size_sel_a: assert property (
    req.wr && req.addr == 8'h02 |=> buffer_size_select == $past(req.wdata[7]))
    else $error("size select mismatch");
  high_flag_a: assert property (
    high_water_flag == (room <= thr_e)) else $error("high flag mismatch");
  low_flag_a: assert property (
    low_water_flag == (fill_count <= thr_e)) else $error("low flag mismatch");
  flush_a: assert property (
    req.wr && req.addr == 8'h02 && req.wdata[4] |-> buffer_clear && !buf_push
    ##1 fill_count == 10'h000) else $error("flush failed");
  push_cnt_a: assert property (
    req.wr && req.addr == 8'h05 && fill_count < 10'h0FF |-> buf_push
    ##1 fill_count == $past(fill_count) + 10'h001) else $error("push count wrong");
  pop_cnt_a: assert property (
    req.rd && req.addr == 8'h05 && fill_count != 10'h000 |-> buf_pop
    ##1 fill_count == $past(fill_count) - 10'h001) else $error("pop count wrong");
  count_rd_a: assert property (
    req.rd && req.addr == 8'h04 |=> rdata == $past(fill_count[7:0]))
    else $error("count readback wrong");
  ctl_rd_a: assert property (
    req.rd && req.addr == 8'h02 |=> {rdata[7:3], rdata[1:0]} == $past(ctl_e))
    else $error("control readback wrong");
endmodule : fcfr_regs_sva
`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench;
  import fcfr_pkg::*;
  logic        core_clk, nrst, buf_push, buf_pop, buffer_clear, buffer_size_select;
  logic        high_water_flag, low_water_flag;
  logic [7:0]  rdata, buf_rdata;
  logic [9:0]  fill_count;
  fcfr_req_s   req;
  fcfr_cmd_s   cmd;
  fcfr_owner_s owner;
  int          num_errors, comparisons, cycles;
  fcfr_regs dut (.core_clk(core_clk), .nrst(nrst), .req(req), .rdata(rdata),
    .buf_rdata(buf_rdata), .buf_push(buf_push), .buf_pop(buf_pop), .buffer_clear(buffer_clear),
    .cmd(cmd), .owner(owner), .buffer_size_select(buffer_size_select), .fill_count(fill_count),
    .high_water_flag(high_water_flag), .low_water_flag(low_water_flag));
  fcfr_buf_model u_buf (.core_clk(core_clk), .nrst(nrst), .buf_push(buf_push), .buf_pop(buf_pop),
    .buffer_clear(buffer_clear), .wdata(req.wdata), .buf_rdata(buf_rdata));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      $display("run timed out");
      num_errors++;
      results();
    end
  end
  // idle edge between accesses keeps one assignment per time step
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge core_clk);
    req <= '0;
    #1;
  endtask : acc
  task automatic t_cmd;
    `CHK("reset count", 10'h000, fill_count)
    `CHK("reset flags", 2'b01, {high_water_flag, low_water_flag})
    acc(1'b1, 8'h00, 8'hC5);
    `CHK("cmd", 8'hCB, cmd)
    acc(1'b0, 8'h00, 8'h00);
    `CHK("cmd rd", 8'hC5, rdata)
    $display("command test done");
  endtask : t_cmd
  task automatic t_owner;
    acc(1'b1, 8'h01, 8'h4C);
    `CHK("locked", 4'h0, owner)
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 8'h01, 8'h80);
      acc(1'b1, 8'h01, (i[0] ? 8'h40 : 8'h20) | 8'(i << 2));
      `CHK("owner", {i[0], !i[0], i[1:0]}, owner)
    end
    acc(1'b1, 8'h01, 8'h80);
    // a read must not use up the unlock
    acc(1'b0, 8'h01, 8'h00);
    `CHK("unlock rd", 8'hCC, rdata)
    acc(1'b1, 8'h01, 8'h60);
    acc(1'b1, 8'h01, 8'h44);
    `CHK("both", 4'h8, owner)
    $display("owner test done");
  endtask : t_owner
  task automatic t_buf;
    acc(1'b1, 8'h03, 8'h02);
    acc(1'b0, 8'h03, 8'h00);
    `CHK("thr rd", 8'h02, rdata)
    for (int i = 0; i < 3; i++) acc(1'b1, 8'h05, 8'hA0 + 8'(i));
    `CHK("push", 10'h003, fill_count)
    acc(1'b0, 8'h04, 8'h00);
    `CHK("count rd", 8'h03, rdata)
    `CHK("low", 1'b0, low_water_flag)
    acc(1'b0, 8'h05, 8'h00);
    `CHK("pop data", 8'hA0, rdata)
    `CHK("low again", 1'b1, low_water_flag)
    acc(1'b1, 8'h02, 8'h14);
    acc(1'b0, 8'h02, 8'h00);
    `CHK("flush", 8'h24, rdata)
    for (int i = 0; i < 300; i++) acc(1'b1, 8'h05, 8'(i));
    acc(1'b0, 8'h02, 8'h00);
    `CHK("ext", 8'h45, rdata)
    acc(1'b1, 8'h02, 8'h10);
    // size changed only on an empty buffer
    acc(1'b1, 8'h02, 8'h84);
    `CHK("small high", 1'b0, high_water_flag)
    for (int i = 0; i < 260; i++) acc(1'b1, 8'h05, 8'(i));
    `CHK("full", 10'h0FF, fill_count)
    acc(1'b0, 8'h02, 8'h00);
    `CHK("small rd", 8'hC0, rdata & 8'hFB)
    acc(1'b0, 8'h40, 8'h00);
    `CHK("unmapped", 8'h00, rdata)
    $display("buffer test done");
  endtask : t_buf
  initial begin
    nrst = 1'b0;
    req = '0;
    num_errors = 0;
    comparisons = 0;
    cycles = 0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    #1;
    t_cmd();
    t_owner();
    t_buf();
    results();
  end
endmodule : testbench
bind fcfr_regs fcfr_regs_sva u_sva (.core_clk(core_clk), .nrst(nrst), .req(req),
  .rdata(rdata), .buf_rdata(buf_rdata), .buf_push(buf_push), .buf_pop(buf_pop),
  .buffer_clear(buffer_clear), .cmd(cmd), .owner(owner), .fill_count(fill_count),
  .buffer_size_select(buffer_size_select), .high_water_flag(high_water_flag),
  .low_water_flag(low_water_flag));
`default_nettype wire
